// *** src/amp_ctrl_pkg.sv ***
// Constants shared by the amplifier control and status register bank
package amp_ctrl_pkg;

    // ========================================================================
    // Register addresses
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h02;
    localparam logic [7:0] ADDR_LEVEL_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CHANNEL_POWER_DOWN = 8'h05;
    localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h06;
    localparam logic [7:0] ADDR_FAULT_CLEAR_CMD = 8'h07;
    localparam logic [7:0] ADDR_SOFT_RESET_CMD = 8'h08;

    // ========================================================================
    // Values after reset
    localparam logic [7:0] RST_MODE_CTRL = 8'h0c;
    localparam logic [7:0] RST_LEVEL_CTRL = 8'h4b;
    localparam logic [1:0] RST_POWER_DOWN = 2'h3;
    localparam logic [3:0] RST_FAULT_FLAGS = 4'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ========================================================================
    // Field positions
    localparam int MODE_OC_RECOVER_BIT = 3;
    localparam int MODE_OT_RECOVER_BIT = 2;
    localparam int LEVEL_FIXED_SEL_BIT = 4;
    localparam int LEVEL_CODE_MSB = 3;
    localparam int PD_RIGHT_BIT = 1;
    localparam int PD_LEFT_BIT = 0;
    localparam int FLAG_RIGHT_OC_BIT = 3;
    localparam int FLAG_LEFT_OC_BIT = 2;
    localparam int FLAG_OT_WARN_BIT = 1;
    localparam int FLAG_OT_ERR_BIT = 0;

    // ========================================================================
    // Fault input synchroniser
    localparam int FAULT_COUNT = 4;
    localparam logic [FAULT_COUNT-1:0] SYNC_RESET = 4'h0;

endpackage

// *** src/level_threshold_decoder.sv ***
// Decodes the level threshold code into a supply share or a fixed power
`timescale 1ns/1ps
module level_threshold_decoder
    import amp_ctrl_pkg::*;
(
    input wire logic [3:0] levelThresholdCode,
    input wire logic thresholdFixedPowerSel,
    output logic [6:0] thresholdPercent,
    output logic [7:0] thresholdPower8Ohm,
    output logic [7:0] thresholdPower4Ohm,
    output logic [7:0] thresholdLimit
);

    // ========================================================================
    // Tables, indexed by code; powers in hundredths of a watt
    localparam logic [6:0] PERCENT_TABLE [16] = '{
        7'd64, 7'd66, 7'd67, 7'd69, 7'd70, 7'd72, 7'd74, 7'd76,
        7'd78, 7'd80, 7'd83, 7'd85, 7'd88, 7'd90, 7'd93, 7'd96};
    localparam logic [7:0] POWER8_TABLE [16] = '{
        8'd42, 8'd46, 8'd50, 8'd54, 8'd59, 8'd63, 8'd68, 8'd73,
        8'd78, 8'd83, 8'd89, 8'd95, 8'd100, 8'd106, 8'd113, 8'd119};
    localparam logic [7:0] POWER4_TABLE [16] = '{
        8'd84, 8'd92, 8'd100, 8'd109, 8'd117, 8'd127, 8'd136, 8'd146,
        8'd156, 8'd167, 8'd178, 8'd189, 8'd201, 8'd213, 8'd225, 8'd238};

    assign thresholdPercent = PERCENT_TABLE[levelThresholdCode]; // RULE1
    assign thresholdPower8Ohm = POWER8_TABLE[levelThresholdCode]; // RULE1
    assign thresholdPower4Ohm = POWER4_TABLE[levelThresholdCode]; // RULE1
    // Mode picks which interpretation the limiter uses
    assign thresholdLimit = thresholdFixedPowerSel ? thresholdPower8Ohm
                                                   : {1'b0, thresholdPercent}; // RULE1 RULE12

endmodule

// *** src/amp_shutdown_fault_regs.sv ***
// Control and status register bank: shutdown, fault flags, commands
//
// Notes on behaviour
// (RULE1) Threshold code decodes to sixteen limits, two modes
// (RULE2) Shutdown bit 1 powers down right, resets 1
// (RULE3) Shutdown bit 0 powers down left, resets 1
// (RULE4) Error register read-only, upper nibble zero
// (RULE5) Bit 3 flags right overcurrent when recovery enabled
// (RULE6) Bit 2 flags left overcurrent when recovery enabled
// (RULE7) Bit 1 flags overtemperature warning, recovery enabled
// (RULE8) Bit 0 flags overtemperature error, recovery enabled
// (RULE9) Error-clear write releases a latched error
// (RULE10) Reset write restores every control register default
// (RULE11) Mode bits 3,2 enable auto recovery, reset 1
// (RULE12) Level bit 4 selects fixed power mode
// (RULE13) Command writes ignore data, read back zero
`timescale 1ns/1ps
module amp_shutdown_fault_regs
    import amp_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic rightOvercurrentIn,
    input wire logic leftOvercurrentIn,
    input wire logic overtempWarningIn,
    input wire logic overtempErrorIn,
    output logic rightPowerDown,
    output logic leftPowerDown,
    output logic overtempWarnActive,
    output logic [3:0] levelThresholdCode,
    output logic thresholdFixedPowerSel,
    output logic [6:0] thresholdPercent,
    output logic [7:0] thresholdPower8Ohm,
    output logic [7:0] thresholdPower4Ohm,
    output logic [7:0] thresholdLimit
);

    // ========================================================================
    // Storage
    logic [7:0] modeCtrl_r;
    logic [7:0] modeCtrl_nxt;
    logic [7:0] levelCtrl_r;
    logic [7:0] levelCtrl_nxt;
    logic [1:0] powerDown_r;
    logic [1:0] powerDown_nxt;
    logic [3:0] faultFlags_r;
    logic [3:0] faultFlags_nxt;
    logic [2:0] faultHold_r;
    logic [2:0] faultHold_nxt;
    logic [FAULT_COUNT-1:0] sync1_r;
    logic [FAULT_COUNT-1:0] sync2_r;
    logic [FAULT_COUNT-1:0] sync3_r;
    logic [FAULT_COUNT-1:0] faultSeen_r;
    logic [FAULT_COUNT-1:0] faultSeen_nxt;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic rdValid_r;

    // ========================================================================
    // Address decode
    wire writeMode = regWrEn && (regAddr == ADDR_MODE_CTRL);
    wire writeLevel = regWrEn && (regAddr == ADDR_LEVEL_CTRL);
    wire writePowerDown = regWrEn && (regAddr == ADDR_CHANNEL_POWER_DOWN);
    // Data is ignored: any write to these addresses fires the command
    wire clearCmd = regWrEn && (regAddr == ADDR_FAULT_CLEAR_CMD); // RULE13
    wire softResetCmd = regWrEn && (regAddr == ADDR_SOFT_RESET_CMD); // RULE13

    wire ocRecover = modeCtrl_r[MODE_OC_RECOVER_BIT]; // RULE11
    wire otRecover = modeCtrl_r[MODE_OT_RECOVER_BIT]; // RULE11

    // ========================================================================
    // Fault input filtering
    // A change is accepted only once the second and third stages agree
    wire [FAULT_COUNT-1:0] rawFault = {rightOvercurrentIn, leftOvercurrentIn,
                                       overtempWarningIn, overtempErrorIn};
    wire [FAULT_COUNT-1:0] syncAgree = ~(sync2_r ^ sync3_r);
    assign faultSeen_nxt = (syncAgree & sync3_r) | (~syncAgree & faultSeen_r);

    wire rightOc = faultSeen_r[FLAG_RIGHT_OC_BIT];
    wire leftOc = faultSeen_r[FLAG_LEFT_OC_BIT];
    wire otWarn = faultSeen_r[FLAG_OT_WARN_BIT];
    wire otErr = faultSeen_r[FLAG_OT_ERR_BIT];

    // ========================================================================
    // Fault flags
    // With recovery on, a flag follows its detector so it clears by itself
    assign faultFlags_nxt[FLAG_RIGHT_OC_BIT] = rightOc && ocRecover; // RULE5
    assign faultFlags_nxt[FLAG_LEFT_OC_BIT] = leftOc && ocRecover; // RULE6
    assign faultFlags_nxt[FLAG_OT_WARN_BIT] = otWarn && otRecover; // RULE7
    assign faultFlags_nxt[FLAG_OT_ERR_BIT] = otErr && otRecover; // RULE8

    // With recovery off, an overcurrent or overtemperature error holds its channel(s) down until cleared.
    // A fault still present during the clear keeps the hold set.
    wire [2:0] holdSet = {rightOc && !ocRecover, leftOc && !ocRecover,
                          otErr && !otRecover};
    wire holdRelease = clearCmd || softResetCmd; // RULE9
    assign faultHold_nxt = holdSet | (holdRelease ? 3'h0 : faultHold_r); // RULE9

    // ========================================================================
    // Control register next values
    // The soft reset command takes priority over a plain write
    assign modeCtrl_nxt = softResetCmd ? RST_MODE_CTRL :
                          writeMode ? regWrData : modeCtrl_r; // RULE10 RULE11
    assign levelCtrl_nxt = softResetCmd ? RST_LEVEL_CTRL :
                           writeLevel ? regWrData : levelCtrl_r; // RULE10 RULE12
    assign powerDown_nxt = softResetCmd ? RST_POWER_DOWN :
                           writePowerDown ? regWrData[1:0] : powerDown_r; // RULE10

    // ========================================================================
    // Read multiplexer
    wire [7:0] readMux = (regAddr == ADDR_MODE_CTRL) ? modeCtrl_r :
                         (regAddr == ADDR_LEVEL_CTRL) ? levelCtrl_r :
                         (regAddr == ADDR_CHANNEL_POWER_DOWN) ? {6'h00, powerDown_r} :
                         (regAddr == ADDR_FAULT_FLAGS) ? {4'h0, faultFlags_r} : // RULE4
                         READ_ZERO; // RULE13
    assign rdData_nxt = regRdEn ? readMux : rdData_r;

    // ========================================================================
    // Flip-flops
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sync1_r <= SYNC_RESET;
            sync2_r <= SYNC_RESET;
            sync3_r <= SYNC_RESET;
            faultSeen_r <= SYNC_RESET;
        end else begin
            sync1_r <= rawFault;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            faultSeen_r <= faultSeen_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            modeCtrl_r <= RST_MODE_CTRL; // RULE11
            levelCtrl_r <= RST_LEVEL_CTRL;
            powerDown_r <= RST_POWER_DOWN; // RULE2 RULE3
        end else begin
            modeCtrl_r <= modeCtrl_nxt;
            levelCtrl_r <= levelCtrl_nxt;
            powerDown_r <= powerDown_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            faultFlags_r <= RST_FAULT_FLAGS; // RULE4
            faultHold_r <= 3'h0;
        end else begin
            faultFlags_r <= faultFlags_nxt;
            faultHold_r <= faultHold_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rdData_r <= READ_ZERO;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= regRdEn;
        end
    end

    // ========================================================================
    // Outputs
    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;
    // A live or held overcurrent shuts its channel; a live or held overtemperature error shuts both
    assign rightPowerDown = powerDown_r[PD_RIGHT_BIT] || rightOc || otErr
                            || faultHold_r[2] || faultHold_r[0]; // RULE2
    assign leftPowerDown = powerDown_r[PD_LEFT_BIT] || leftOc || otErr
                           || faultHold_r[1] || faultHold_r[0]; // RULE3
    assign overtempWarnActive = otWarn;
    assign levelThresholdCode = levelCtrl_r[LEVEL_CODE_MSB:0];
    assign thresholdFixedPowerSel = levelCtrl_r[LEVEL_FIXED_SEL_BIT]; // RULE12

    level_threshold_decoder thresholdDecoder (
        .levelThresholdCode(levelThresholdCode),
        .thresholdFixedPowerSel(thresholdFixedPowerSel),
        .thresholdPercent(thresholdPercent),
        .thresholdPower8Ohm(thresholdPower8Ohm),
        .thresholdPower4Ohm(thresholdPower4Ohm),
        .thresholdLimit(thresholdLimit)
    );

endmodule

// *** verif/amp_host_model.sv ***
// Host model driving the register bus of the amplifier bank
`timescale 1ns/1ps
module amp_host_model (
    input wire logic clock,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    output logic regWrEn,
    output logic regRdEn
);
    // ========================================================================
    // Bus cycle
    initial begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
    end
    // Idle address and data inverted so stale values never look current
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = wr;
        regRdEn = !wr;
        @(posedge clock);
        #1;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
endmodule

// *** verif/amp_shutdown_fault_regs_chk.sv ***
// Port checks for the amplifier register bank
`timescale 1ns/1ps
module amp_shutdown_fault_regs_chk
    import amp_ctrl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic rightPowerDown,
    input wire logic leftPowerDown,
    input wire logic [3:0] levelThresholdCode,
    input wire logic thresholdFixedPowerSel,
    input wire logic [6:0] thresholdPercent,
    input wire logic [7:0] thresholdPower8Ohm,
    input wire logic [7:0] thresholdLimit
);
    // ========================================================================
    // Assertions
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence rdAt(logic [7:0] a); regRdEn && regAddr == a; endsequence
    sequence wrAt(logic [7:0] a); regWrEn && regAddr == a; endsequence
    chk_read_answer: assert property (regRdEn |=> regRdValid)
        else $error("read strobe got no valid");
    chk_no_stray_valid: assert property (!regRdEn |=> !regRdValid)
        else $error("valid without read strobe");
    chk_pd_upper_zero: assert property (rdAt(8'h05) |=> regRdData[7:2] == 6'h00)
        else $error("shutdown readback upper bits set");
    chk_flags_upper_zero: assert property (rdAt(8'h06) |=> regRdData[7:4] == 4'h0)
        else $error("flag readback upper bits set");
    chk_cmd_read_zero: assert property ((rdAt(8'h07) or rdAt(8'h08))
        |=> regRdData == 8'h00)
        else $error("command register read not zero");
    chk_right_down: assert property (wrAt(8'h05) ##0 regWrData[1] |=> rightPowerDown)
        else $error("right channel not powered down");
    chk_left_down: assert property (wrAt(8'h05) ##0 regWrData[0] |=> leftPowerDown)
        else $error("left channel not powered down");
    chk_soft_defaults: assert property (wrAt(8'h08) |=> rightPowerDown && leftPowerDown
        && levelThresholdCode == 4'hb && !thresholdFixedPowerSel)
        else $error("soft reset left registers changed");
    chk_limit_select: assert property (thresholdLimit ==
        (thresholdFixedPowerSel ? thresholdPower8Ohm : {1'b0, thresholdPercent}))
        else $error("limit follows wrong mode");
    chk_percent_ends: assert property ((levelThresholdCode == 4'h0 |-> thresholdPercent == 7'h40)
        and (levelThresholdCode == 4'hf |-> thresholdPercent == 7'h60))
        else $error("threshold end code wrong");
endmodule

bind amp_shutdown_fault_regs amp_shutdown_fault_regs_chk i_chk (.clock(clock), .rst_b(rst_b),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid), .rightPowerDown(rightPowerDown),
    .leftPowerDown(leftPowerDown), .levelThresholdCode(levelThresholdCode),
    .thresholdFixedPowerSel(thresholdFixedPowerSel), .thresholdPercent(thresholdPercent),
    .thresholdPower8Ohm(thresholdPower8Ohm), .thresholdLimit(thresholdLimit));

// *** verif/amp_shutdown_fault_regs_tb_top.sv ***
// Self-checking bench for the amplifier register bank
`timescale 1ns/1ps
module amp_shutdown_fault_regs_tb_top;
    import amp_ctrl_pkg::*;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] faults = 4'h0;
    logic [15:0] seed = 16'h683f;
    logic [7:0] regAddr, regWrData, regRdData, thresholdLimit;
    logic [7:0] thresholdPower8Ohm, thresholdPower4Ohm;
    logic regWrEn, regRdEn, regRdValid, rightPowerDown, leftPowerDown, overtempWarnActive;
    logic thresholdFixedPowerSel;
    logic [3:0] levelThresholdCode;
    logic [6:0] thresholdPercent;
    logic [7:0] expQ[$];
    int bad_count = 0;
    int checked = 0;
    localparam logic [6:0] PCT[16] = '{7'h40, 7'h42, 7'h43, 7'h45, 7'h46, 7'h48, 7'h4a, 7'h4c,
        7'h4e, 7'h50, 7'h53, 7'h55, 7'h58, 7'h5a, 7'h5d, 7'h60};
    localparam logic [7:0] PW8[16] = '{8'h2a, 8'h2e, 8'h32, 8'h36, 8'h3b, 8'h3f, 8'h44, 8'h49,
        8'h4e, 8'h53, 8'h59, 8'h5f, 8'h64, 8'h6a, 8'h71, 8'h77};
    localparam logic [7:0] PW4[16] = '{8'h54, 8'h5c, 8'h64, 8'h6d, 8'h75, 8'h7f, 8'h88, 8'h92,
        8'h9c, 8'ha7, 8'hb2, 8'hbd, 8'hc9, 8'hd5, 8'he1, 8'hee};
    always #25 clock = ~clock;
    amp_host_model host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn));
    amp_shutdown_fault_regs i_amp_shutdown_fault_regs (.clock(clock), .rst_b(rst_b),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid), .rightOvercurrentIn(faults[3]),
        .leftOvercurrentIn(faults[2]), .overtempWarningIn(faults[1]), .overtempErrorIn(faults[0]),
        .rightPowerDown(rightPowerDown), .leftPowerDown(leftPowerDown),
        .overtempWarnActive(overtempWarnActive), .levelThresholdCode(levelThresholdCode),
        .thresholdFixedPowerSel(thresholdFixedPowerSel), .thresholdPercent(thresholdPercent),
        .thresholdPower8Ohm(thresholdPower8Ohm), .thresholdPower4Ohm(thresholdPower4Ohm),
        .thresholdLimit(thresholdLimit));
    // ========================================================================
    // Helpers
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        host.xfer(1'b0, a, 8'h00);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic tally_and_finish;
        $display("counts: checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clock) begin
        if (regRdValid === 1'b1) check(regRdData, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
    end
    initial begin
        #3000000;
        bad_count++;
        tally_and_finish();
    end
    // ========================================================================
    // Scenarios
    initial begin
        logic [7:0] v;
        idle(20);
        rst_b = 1'b1;
        rd(8'h05, 8'h03);
        rd(8'h06, 8'h00);
        rd(8'h02, 8'h0c);
        rd(8'h04, 8'h4b);
        rd(8'h07, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h3f, 8'h00);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            v = {seed[7:2], i[1:0]};
            host.xfer(1'b1, 8'h05, v);
            check({7'h0, rightPowerDown}, {7'h0, v[1]});
            check({7'h0, leftPowerDown}, {7'h0, v[0]});
            rd(8'h05, {6'h0, v[1:0]});
            host.xfer(1'b1, 8'h06, seed[15:8]);
            rd(8'h06, 8'h00);
        end
        $display("shutdown done");
        for (int i = 0; i < 32; i++) begin
            seed = lfsr(seed);
            v = {seed[2:0], i[4:0]};
            host.xfer(1'b1, 8'h04, v);
            check({1'b0, thresholdPercent}, {1'b0, PCT[i[3:0]]});
            check(thresholdPower8Ohm, PW8[i[3:0]]);
            check(thresholdPower4Ohm, PW4[i[3:0]]);
            check(thresholdLimit, i[4] ? PW8[i[3:0]] : {1'b0, PCT[i[3:0]]});
            rd(8'h04, v);
        end
        $display("threshold done");
        host.xfer(1'b1, 8'h05, 8'h00);
        for (int b = 0; b < 4; b++) begin
            faults = 4'h1 << b;
            idle(8);
            check({7'h0, rightPowerDown}, {7'h0, b == 3 || b == 0});
            check({7'h0, leftPowerDown}, {7'h0, b == 2 || b == 0});
            check({7'h0, overtempWarnActive}, {7'h0, b == 1});
            rd(8'h06, 8'h01 << b);
            faults = 4'h0;
            idle(8);
            rd(8'h06, 8'h00);
        end
        $display("auto recovery done");
        host.xfer(1'b1, 8'h02, 8'h00);
        for (int b = 0; b < 4; b++) begin
            faults = 4'h1 << b;
            idle(8);
            rd(8'h06, 8'h00);
            // Clear while the fault is still live: the hold must survive
            seed = lfsr(seed);
            host.xfer(1'b1, 8'h07, seed[7:0]);
            faults = 4'h0;
            idle(8);
            check({7'h0, rightPowerDown}, {7'h0, b == 3 || b == 0});
            check({7'h0, leftPowerDown}, {7'h0, b == 2 || b == 0});
            host.xfer(1'b1, 8'h07, seed[15:8]);
            check({7'h0, rightPowerDown}, 8'h00);
            check({7'h0, leftPowerDown}, 8'h00);
        end
        host.xfer(1'b1, 8'h04, 8'h1f);
        host.xfer(1'b1, 8'h08, seed[15:8]);
        rd(8'h05, 8'h03);
        rd(8'h02, 8'h0c);
        rd(8'h04, 8'h4b);
        $display("latched faults done");
        host.xfer(1'b1, 8'h05, 8'h00);
        host.xfer(1'b1, 8'h04, 8'h10);
        rst_b = 1'b0;
        idle(2);
        rst_b = 1'b1;
        rd(8'h05, 8'h03);
        rd(8'h04, 8'h4b);
        $display("hardware reset done");
        for (int i = 0; i < 20 && expQ.size() > 0; i++) idle(1);
        if (expQ.size() > 0) bad_count++;
        tally_and_finish();
    end
endmodule
